// ### hw/ira_pkg.sv
`default_nettype none
package ira_pkg;
	// Request address and data field positions.
	localparam int ADR_HANDLE_HI = 19;
	localparam int ADR_HANDLE_LO = 5;
	localparam int ADR_FMT_POS   = 4;
	localparam int ADR_SHV_POS   = 3;
	localparam int ADR_H15_POS   = 2;
	localparam int DAT_RSVD_HI   = 31;
	localparam int DAT_RSVD_LO   = 16;
	localparam int DAT_SUB_HI    = 15;
	localparam int DAT_SUB_LO    = 0;
	// Entry size is 128 bits, so an index is scaled by 16 bytes.
	localparam int ENTRY_SHIFT   = 4;
	localparam logic [16:0] TBL_MAX_ENTRIES = 17'h10000;
	// Fault reason codes.
	localparam logic [7:0] FLT_RSVD  = 8'h20;
	localparam logic [7:0] FLT_RANGE = 8'h21;
	localparam logic [7:0] FLT_FETCH = 8'h23;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_BASE_LO = 8'h04;
	localparam logic [7:0] OFS_BASE_HI = 8'h08;
	localparam logic [7:0] OFS_COUNT   = 8'h0C;
	localparam logic [7:0] OFS_STATUS  = 8'h10;
	localparam logic [7:0] OFS_LAST    = 8'h14;
	localparam logic [7:0] OFS_INV_IDX = 8'h18;
	// Control and status bit positions.
	localparam int CTRL_EN_POS   = 0;
	localparam int CTRL_INV_POS  = 1;
	localparam int STS_FLT_POS   = 8;
	localparam int STS_SZERR_POS = 9;
	localparam int STS_BUSY_POS  = 10;
	// Values after reset.
	localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
	localparam logic [63:0] RST_BASE  = 64'h0000_0000_0000_0000;
	localparam logic [16:0] RST_COUNT = 17'h00000;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_FETCH, ST_WAIT} ira_state_t;
endpackage
`default_nettype wire

// ### hw/ira_index_calc.sv
`default_nettype none
module ira_index_calc
	import ira_pkg::*;
(
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] data_in,
	output logic      [15:0] handle_out,
	output logic             shv_out,
	output logic             remappable_out,
	output logic             rsvd_err_out,
	output logic      [16:0] index_out
);
	logic [15:0] sub;

	// Handle gathers address bits 2 and 19:5; bits 1:0 are never looked at.
	assign handle_out = {addr_in[ADR_H15_POS], addr_in[ADR_HANDLE_HI:ADR_HANDLE_LO]};
	assign shv_out        = addr_in[ADR_SHV_POS];
	assign remappable_out = addr_in[ADR_FMT_POS];
	// Data is only meaningful when the subhandle-valid flag is set.
	assign sub          = shv_out ? data_in[DAT_SUB_HI:DAT_SUB_LO] : 16'h0000;
	assign rsvd_err_out = shv_out && (data_in[DAT_RSVD_HI:DAT_RSVD_LO] != 16'h0000);
	// A 17-bit sum keeps the carry, so a wrapped sum fails the bounds check.
	assign index_out = {1'b0, handle_out} + {1'b0, sub};
endmodule // ira_index_calc
`default_nettype wire

// ### hw/ira_entry_cache.sv
`default_nettype none
module ira_entry_cache
	import ira_pkg::*;
#(
	parameter int DEPTH = 16
)(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [15:0]  lk_idx_in,
	output logic              hit_out,
	output logic      [127:0] lk_data_out,
	input  wire logic         fill_in,
	input  wire logic [15:0]  fill_idx_in,
	input  wire logic [127:0] fill_data_in,
	input  wire logic         inv_all_in,
	input  wire logic         inv_one_in,
	input  wire logic [15:0]  inv_idx_in
);
	localparam int AW = $clog2(DEPTH);
	logic [127:0]   ent_r [DEPTH];
	logic [15-AW:0] tag_r [DEPTH];
	logic [DEPTH-1:0] vld_r;

	// Direct-mapped lookup on the low index bits.
	assign hit_out     = vld_r[lk_idx_in[AW-1:0]] && (tag_r[lk_idx_in[AW-1:0]] == lk_idx_in[15:AW]);
	assign lk_data_out = ent_r[lk_idx_in[AW-1:0]];

	// Entry storage needs no reset; validity guards it.
	always_ff @(posedge clk_in) begin
		if (fill_in) begin
			ent_r[fill_idx_in[AW-1:0]] <= fill_data_in;
			tag_r[fill_idx_in[AW-1:0]] <= fill_idx_in[15:AW];
		end
	end

	// A flush beats a fill, so a stale entry never survives a flush.
	always_ff @(posedge clk_in) begin
		if (rst_in || inv_all_in) begin
			vld_r <= '0;
		end else begin
			if (fill_in) begin
				vld_r[fill_idx_in[AW-1:0]] <= 1'b1;
			end
			if (inv_one_in && tag_r[inv_idx_in[AW-1:0]] == inv_idx_in[15:AW]) begin
				vld_r[inv_idx_in[AW-1:0]] <= 1'b0;
			end
		end
	end

	// A flush leaves no entry valid.
	a_flush_clears: assert property (@(posedge clk_in) disable iff (rst_in)
		inv_all_in |=> (vld_r == '0))
		else $error("cache entries survived a flush");
endmodule // ira_entry_cache
`default_nettype wire

// ### hw/ira_remap_index.sv
`default_nettype none
// What this block does
// - Address bit 3 flags a valid subhandle.
// - Address bit 2 is handle bit 15.
// - Address bits 1:0 are ignored.
// - With subhandle, data 31:16 must be zero.
// - With subhandle, data 15:0 is the subhandle.
// - Index is handle, plus subhandle when flagged.
// - Table base and count come from software.
// - Each entry is a 128-bit record.
// - Table size limited to 64K entries.
// - Index at or above count is blocked.
// - Range or address-width fault reports 21h.
// - Delivered attributes come from the entry.
// - Entry cache; a flush drops every entry, an index invalidation drops only the matching entry.
module ira_remap_index
	import ira_pkg::*;
#(
	parameter int HOST_ADDR_WIDTH = 48,
	parameter int CACHE_DEPTH     = 16
)(
	input  wire logic         CLOCK_IN,
	input  wire logic         RST_IN,
	input  wire logic [7:0]   S_AXI_AWADDR,
	input  wire logic         S_AXI_AWVALID,
	output logic              S_AXI_AWREADY,
	input  wire logic [31:0]  S_AXI_WDATA,
	input  wire logic [3:0]   S_AXI_WSTRB,
	input  wire logic         S_AXI_WVALID,
	output logic              S_AXI_WREADY,
	output logic      [1:0]   S_AXI_BRESP,
	output logic              S_AXI_BVALID,
	input  wire logic         S_AXI_BREADY,
	input  wire logic [7:0]   S_AXI_ARADDR,
	input  wire logic         S_AXI_ARVALID,
	output logic              S_AXI_ARREADY,
	output logic      [31:0]  S_AXI_RDATA,
	output logic      [1:0]   S_AXI_RRESP,
	output logic              S_AXI_RVALID,
	input  wire logic         S_AXI_RREADY,
	input  wire logic         REQ_VALID_IN,
	output logic              REQ_READY_OUT,
	input  wire logic [31:0]  REQ_ADDR_IN,
	input  wire logic [31:0]  REQ_DATA_IN,
	output logic              MEM_REQ_VALID_OUT,
	input  wire logic         MEM_REQ_READY_IN,
	output logic      [63:0]  MEM_ADDR_OUT,
	input  wire logic         MEM_RSP_VALID_IN,
	input  wire logic [127:0] MEM_RSP_DATA_IN,
	input  wire logic         MEM_RSP_ERR_IN,
	output logic              DLV_VALID_OUT,
	output logic      [127:0] DLV_ENTRY_OUT,
	output logic      [15:0]  DLV_INDEX_OUT,
	output logic              COMPAT_VALID_OUT,
	output logic              FAULT_VALID_OUT,
	output logic      [7:0]   FAULT_REASON_OUT
);
	ira_state_t    state_r;
	logic [31:0]   req_addr_r;
	logic [31:0]   req_data_r;
	logic [31:0]   ctrl_r;
	logic [63:0]   base_r;
	logic [16:0]   count_r;
	logic          flt_sticky_r;
	logic          szerr_r;
	logic [7:0]    last_code_r;
	logic [15:0]   last_idx_r;
	logic          aw_held_r;
	logic          w_held_r;
	logic [7:0]    awaddr_r;
	logic [31:0]   wdata_r;
	logic [3:0]    wstrb_r;
	logic          bvalid_r;
	logic [1:0]    bresp_r;
	logic          rvalid_r;
	logic [31:0]   rdata_r;
	logic [1:0]    rresp_r;
	logic          inv_all_r;
	logic          inv_one_r;
	logic [15:0]   inv_idx_r;
	logic          dlv_r;
	logic [127:0]  dlv_entry_r;
	logic [15:0]   dlv_idx_r;
	logic          compat_r;
	logic          flt_r;
	logic [7:0]    flt_code_r;
	logic [15:0]   handle;
	logic          subhandle_valid_flag;
	logic          remappable;
	logic          rsvd_err;
	logic [16:0]   idx17;
	logic [63:0]   ent_addr;
	logic          over_haw;
	logic          hit;
	logic [127:0]  hit_data;
	logic          aw_hs;
	logic          w_hs;
	logic          do_wr;
	logic [7:0]    wr_addr;
	logic [31:0]   wr_data;
	logic [3:0]    wr_strb;
	logic          mem_fill;
	logic          flt_event;
	logic [31:0]   count_wr;
	logic [31:0]   inv_idx_wr;

	// Byte-lane merge of a write into an existing register value.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Field extraction and index arithmetic on the captured request.
	ira_index_calc u_calc (
		.addr_in        (req_addr_r),
		.data_in        (req_data_r),
		.handle_out     (handle),
		.shv_out        (subhandle_valid_flag),
		.remappable_out (remappable),
		.rsvd_err_out   (rsvd_err),
		.index_out      (idx17)
	);

	// Entry location and its check against the host address width.
	assign ent_addr = base_r + {44'h0, idx17[15:0], 4'h0};
	assign over_haw = (ent_addr >> HOST_ADDR_WIDTH) != 64'h0;
	assign mem_fill = (state_r == ST_WAIT) && MEM_RSP_VALID_IN && !MEM_RSP_ERR_IN;

	ira_entry_cache #(.DEPTH(CACHE_DEPTH)) u_cache (
		.clk_in       (CLOCK_IN),
		.rst_in       (RST_IN),
		.lk_idx_in    (idx17[15:0]),
		.hit_out      (hit),
		.lk_data_out  (hit_data),
		.fill_in      (mem_fill),
		.fill_idx_in  (idx17[15:0]),
		.fill_data_in (MEM_RSP_DATA_IN),
		.inv_all_in   (inv_all_r),
		.inv_one_in   (inv_one_r),
		.inv_idx_in   (inv_idx_r)
	);

	// Requests are taken only while idle and the block is enabled.
	assign REQ_READY_OUT     = (state_r == ST_IDLE) && ctrl_r[CTRL_EN_POS];
	assign MEM_REQ_VALID_OUT = (state_r == ST_FETCH);
	assign MEM_ADDR_OUT      = ent_addr;
	assign DLV_VALID_OUT     = dlv_r;
	assign DLV_ENTRY_OUT     = dlv_entry_r;
	assign DLV_INDEX_OUT     = dlv_idx_r;
	assign COMPAT_VALID_OUT  = compat_r;
	assign FAULT_VALID_OUT   = flt_r;
	assign FAULT_REASON_OUT  = flt_code_r;

	// Captures a request; address bits 1:0 are kept but never decoded.
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			req_addr_r <= 32'h0000_0000;
			req_data_r <= 32'h0000_0000;
		end else if (REQ_VALID_IN && REQ_READY_OUT) begin
			req_addr_r <= REQ_ADDR_IN;
			req_data_r <= REQ_DATA_IN;
		end
	end

	// Sequencer: checks, then cache lookup or table fetch.
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (REQ_VALID_IN && REQ_READY_OUT) begin
						state_r <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (remappable && !rsvd_err && idx17 < count_r && !over_haw && !hit) begin
						state_r <= ST_FETCH;
					end else begin
						state_r <= ST_IDLE;
					end
				end
				ST_FETCH: begin
					if (MEM_REQ_READY_IN) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (MEM_RSP_VALID_IN) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Outcome pulses: fault, pass-on of a compatibility request, or delivery.
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			dlv_r       <= 1'b0;
			dlv_entry_r <= 128'h0;
			dlv_idx_r   <= 16'h0000;
			compat_r    <= 1'b0;
			flt_r       <= 1'b0;
			flt_code_r  <= 8'h00;
		end else begin
			dlv_r    <= 1'b0;
			compat_r <= 1'b0;
			flt_r    <= 1'b0;
			if (state_r == ST_CHECK) begin
				if (!remappable) begin
					compat_r <= 1'b1;
				end else if (rsvd_err) begin
					flt_r      <= 1'b1;
					flt_code_r <= FLT_RSVD;
				end else if (idx17 >= count_r || over_haw) begin
					flt_r      <= 1'b1;
					flt_code_r <= FLT_RANGE;
				end else if (hit) begin
					dlv_r       <= 1'b1;
					dlv_entry_r <= hit_data;
					dlv_idx_r   <= idx17[15:0];
				end
			end else if (state_r == ST_WAIT && MEM_RSP_VALID_IN) begin
				if (MEM_RSP_ERR_IN) begin
					flt_r      <= 1'b1;
					flt_code_r <= FLT_FETCH;
				end else begin
					dlv_r       <= 1'b1;
					dlv_entry_r <= MEM_RSP_DATA_IN;
					dlv_idx_r   <= idx17[15:0];
				end
			end
		end
	end

	// Bus write side: address and data may arrive in either order.
	assign aw_hs         = S_AXI_AWVALID && S_AXI_AWREADY;
	assign w_hs          = S_AXI_WVALID && S_AXI_WREADY;
	assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
	assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
	assign do_wr         = (aw_held_r || aw_hs) && (w_held_r || w_hs);
	assign wr_addr       = aw_held_r ? awaddr_r : S_AXI_AWADDR;
	assign wr_data       = w_held_r ? wdata_r : S_AXI_WDATA;
	assign wr_strb       = w_held_r ? wstrb_r : S_AXI_WSTRB;
	assign S_AXI_BVALID  = bvalid_r;
	assign S_AXI_BRESP   = bresp_r;

	// Holds whichever half of a write came first, then answers.
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (do_wr) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (wr_addr[1:0] == 2'h0 && wr_addr <= OFS_INV_IDX) ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (aw_hs) begin
					aw_held_r <= 1'b1;
					awaddr_r  <= S_AXI_AWADDR;
				end
				if (w_hs) begin
					w_held_r <= 1'b1;
					wdata_r  <= S_AXI_WDATA;
					wstrb_r  <= S_AXI_WSTRB;
				end
				if (bvalid_r && S_AXI_BREADY) begin
					bvalid_r <= 1'b0;
				end
			end
		end
	end

	// Candidate register values after the byte-lane merge of the current write.
	assign count_wr   = merge({15'h0, count_r}, wr_data, wr_strb);
	assign inv_idx_wr = merge({16'h0, inv_idx_r}, wr_data, wr_strb);

	// Software-written configuration and invalidation commands.
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			ctrl_r    <= RST_CTRL;
			base_r    <= RST_BASE;
			count_r   <= RST_COUNT;
			inv_all_r <= 1'b0;
			inv_one_r <= 1'b0;
			inv_idx_r <= 16'h0000;
		end else begin
			inv_all_r <= 1'b0;
			inv_one_r <= 1'b0;
			if (do_wr) begin
				unique case (wr_addr)
					OFS_CTRL: begin
						ctrl_r    <= merge(ctrl_r, wr_data, wr_strb) & 32'h0000_0001;
						inv_all_r <= wr_strb[0] && wr_data[CTRL_INV_POS];
					end
					OFS_BASE_LO: base_r[31:0]  <= merge(base_r[31:0], wr_data, wr_strb);
					OFS_BASE_HI: base_r[63:32] <= merge(base_r[63:32], wr_data, wr_strb);
					OFS_COUNT: begin
						if (count_wr <= {15'h0, TBL_MAX_ENTRIES}) begin
							count_r <= count_wr[16:0];
						end
					end
					OFS_INV_IDX: begin
						inv_one_r <= 1'b1;
						inv_idx_r <= inv_idx_wr[15:0];
					end
					default: ;
				endcase
			end
		end
	end

	// Sticky status; a new event wins over a same-cycle clear.
	assign flt_event = flt_r;
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			flt_sticky_r <= 1'b0;
			szerr_r      <= 1'b0;
			last_code_r  <= 8'h00;
			last_idx_r   <= 16'h0000;
		end else begin
			if (do_wr && wr_addr == OFS_STATUS && wr_strb[1]) begin
				if (wr_data[STS_FLT_POS]) flt_sticky_r <= 1'b0;
				if (wr_data[STS_SZERR_POS]) szerr_r <= 1'b0;
			end
			if (flt_event) begin
				flt_sticky_r <= 1'b1;
				last_code_r  <= flt_code_r;
			end
			if (do_wr && wr_addr == OFS_COUNT && count_wr > {15'h0, TBL_MAX_ENTRIES}) begin
				szerr_r <= 1'b1;
			end
			if (state_r == ST_CHECK) begin
				last_idx_r <= idx17[15:0];
			end
		end
	end

	// Bus read side: one read at a time, answer one cycle after address.
	assign S_AXI_ARREADY = !rvalid_r;
	assign S_AXI_RVALID  = rvalid_r;
	assign S_AXI_RDATA   = rdata_r;
	assign S_AXI_RRESP   = rresp_r;
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_r <= 1'b1;
			rresp_r  <= RESP_OKAY;
			unique case (S_AXI_ARADDR)
				OFS_CTRL:    rdata_r <= ctrl_r;
				OFS_BASE_LO: rdata_r <= base_r[31:0];
				OFS_BASE_HI: rdata_r <= base_r[63:32];
				OFS_COUNT:   rdata_r <= {15'h0, count_r};
				OFS_STATUS:  rdata_r <= {21'h0, (state_r != ST_IDLE), szerr_r, flt_sticky_r,
					last_code_r};
				OFS_LAST:    rdata_r <= {16'h0, last_idx_r};
				OFS_INV_IDX: rdata_r <= {16'h0, inv_idx_r};
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	a_range_fault: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(state_r == ST_CHECK && remappable && !rsvd_err && idx17 >= count_r)
		|=> (FAULT_VALID_OUT && FAULT_REASON_OUT == 8'h21 && !DLV_VALID_OUT))
		else $error("out-of-range index not faulted with 21h");
	a_rsvd_fault: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(state_r == ST_CHECK && remappable && req_addr_r[3] && req_data_r[31:16] != 16'h0)
		|=> (FAULT_VALID_OUT && FAULT_REASON_OUT == 8'h20))
		else $error("nonzero reserved data not faulted");
	a_index_plain: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(state_r == ST_CHECK && !req_addr_r[3]) |-> (idx17 == {1'b0, handle}))
		else $error("index differs from handle without subhandle");
	a_index_sum: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(state_r == ST_CHECK && req_addr_r[3])
		|-> (idx17 == {1'b0, handle} + {1'b0, req_data_r[15:0]}))
		else $error("index is not handle plus subhandle");
	a_handle_msb: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(state_r == ST_CHECK) |-> (handle == {req_addr_r[2], req_addr_r[19:5]}))
		else $error("handle not built from address bits 2 and 19:5");
	a_fetch_addr: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		MEM_REQ_VALID_OUT |-> (MEM_ADDR_OUT == base_r + 64'(idx17[15:0]) * 64'd16))
		else $error("entry fetched from wrong address");
	a_size_limit: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		count_r <= 17'h10000)
		else $error("table size above 64K entries");
	a_deliver_src: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(state_r == ST_WAIT && MEM_RSP_VALID_IN && !MEM_RSP_ERR_IN)
		|=> (DLV_VALID_OUT && DLV_ENTRY_OUT == $past(MEM_RSP_DATA_IN)
			&& DLV_INDEX_OUT == $past(idx17[15:0])))
		else $error("delivered entry is not the fetched one");
endmodule // ira_remap_index
`default_nettype wire

// ### tb/ira_mem_model.sv
`default_nettype none
module ira_mem_model (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         req_valid_in,
	input  wire logic [63:0]  addr_in,
	input  wire logic         slow_in,
	input  wire logic         err_in,
	output logic              ready_out,
	output logic              rsp_valid_out,
	output logic      [127:0] rsp_data_out,
	output logic              rsp_err_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        pend_r;
	logic [2:0]  dly_r;
	logic [1:0]  stall_r;
	logic [63:0] addr_r;
	// A fetch is taken only once the stall count has run out and nothing is pending.
	assign ready_out = req_valid_in && (stall_r == 2'h0) && !pend_r;
	// Outside the answer cycle the lines show the inverse pattern, never stale data.
	assign rsp_data_out = rsp_valid_out ? {~addr_r, addr_r} : {addr_r, ~addr_r};
	assign rsp_err_out = rsp_valid_out ? err_in : ~err_in;
	// In slow mode stall the request, then answer exactly once after a short or long delay.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pend_r <= 1'b0;
			dly_r <= 3'h0;
			stall_r <= 2'h0;
			addr_r <= 64'h0;
			rsp_valid_out <= 1'b0;
		end else begin
			rsp_valid_out <= 1'b0;
			if (!req_valid_in) stall_r <= slow_in ? 2'h3 : 2'h0;
			else if (stall_r != 2'h0) stall_r <= stall_r - 2'h1;
			if (ready_out) begin
				pend_r <= 1'b1;
				addr_r <= addr_in;
				dly_r <= slow_in ? 3'h4 : 3'h0;
			end else if (pend_r && dly_r != 3'h0) begin
				dly_r <= dly_r - 3'h1;
			end else if (pend_r) begin
				pend_r <= 1'b0;
				rsp_valid_out <= 1'b1;
			end
		end
	end
endmodule // ira_mem_model
`default_nettype wire

// ### tb/test_remappable_irq_index_decode.sv
`default_nettype none
module test_remappable_irq_index_decode import ira_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic         CLOCK_IN = 1'b0, RST_IN, REQ_VALID_IN, REQ_READY_OUT, mem_slow, mem_err;
	logic         S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic         S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic         S_AXI_RVALID, S_AXI_RREADY, MEM_REQ_VALID_OUT, MEM_REQ_READY_IN;
	logic         MEM_RSP_VALID_IN, MEM_RSP_ERR_IN, DLV_VALID_OUT, COMPAT_VALID_OUT;
	logic         FAULT_VALID_OUT;
	logic [1:0]   S_AXI_BRESP, S_AXI_RRESP;
	logic [3:0]   S_AXI_WSTRB;
	logic [7:0]   S_AXI_AWADDR, S_AXI_ARADDR, FAULT_REASON_OUT;
	logic [15:0]  DLV_INDEX_OUT;
	logic [31:0]  S_AXI_WDATA, S_AXI_RDATA, REQ_ADDR_IN, REQ_DATA_IN, rv;
	logic [63:0]  MEM_ADDR_OUT, base;
	logic [127:0] MEM_RSP_DATA_IN, DLV_ENTRY_OUT;
	int           fail_count, checks_done, fetches, f0;

	ira_remap_index #(.HOST_ADDR_WIDTH(48), .CACHE_DEPTH(16)) DUT (
		.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .REQ_VALID_IN(REQ_VALID_IN),
		.REQ_READY_OUT(REQ_READY_OUT), .REQ_ADDR_IN(REQ_ADDR_IN), .REQ_DATA_IN(REQ_DATA_IN),
		.MEM_REQ_VALID_OUT(MEM_REQ_VALID_OUT), .MEM_REQ_READY_IN(MEM_REQ_READY_IN),
		.MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RSP_VALID_IN(MEM_RSP_VALID_IN),
		.MEM_RSP_DATA_IN(MEM_RSP_DATA_IN), .MEM_RSP_ERR_IN(MEM_RSP_ERR_IN),
		.DLV_VALID_OUT(DLV_VALID_OUT), .DLV_ENTRY_OUT(DLV_ENTRY_OUT),
		.DLV_INDEX_OUT(DLV_INDEX_OUT), .COMPAT_VALID_OUT(COMPAT_VALID_OUT),
		.FAULT_VALID_OUT(FAULT_VALID_OUT), .FAULT_REASON_OUT(FAULT_REASON_OUT));

	ira_mem_model mem (.clk_in(CLOCK_IN), .rst_in(RST_IN), .req_valid_in(MEM_REQ_VALID_OUT),
		.addr_in(MEM_ADDR_OUT), .slow_in(mem_slow), .err_in(mem_err),
		.ready_out(MEM_REQ_READY_IN), .rsp_valid_out(MEM_RSP_VALID_IN),
		.rsp_data_out(MEM_RSP_DATA_IN), .rsp_err_out(MEM_RSP_ERR_IN));

	// The clock toggles every half period of 10 ns.
	always #10 CLOCK_IN = ~CLOCK_IN;

	// Count table fetches handed to memory, so cache hits can be told from misses.
	always @(posedge CLOCK_IN) begin
		if (MEM_REQ_VALID_OUT && MEM_REQ_READY_IN) fetches++;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic tmo;
		fail_count++;
		test_done();
	endtask

	// Address of a remappable request with the handle split around the format and flag bits.
	function automatic logic [31:0] ra(input logic [15:0] h, input logic s, input logic [1:0] lo);
		return {12'hFEE, h[14:0], 1'b1, s, h[15], lo};
	endfunction

	// Register write: both halves offered together, each released once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w, got;
		logic [1:0] r;
		got = 1'b0;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		for (n = 0; n < 50 && !got; n++) begin
			@(negedge CLOCK_IN);
			aw = S_AXI_AWVALID && S_AXI_AWREADY;
			w = S_AXI_WVALID && S_AXI_WREADY;
			got = S_AXI_BVALID;
			r = S_AXI_BRESP;
			@(posedge CLOCK_IN);
			if (aw) S_AXI_AWVALID <= 1'b0;
			if (w) S_AXI_WVALID <= 1'b0;
		end
		S_AXI_BREADY <= 1'b0;
		if (!got) tmo();
		chk(r, er);
		@(posedge CLOCK_IN);
	endtask

	// Register read: the address is held until taken, the data caught with the answer.
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		int n;
		logic ar, got;
		logic [1:0] r;
		got = 1'b0;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		for (n = 0; n < 50 && !got; n++) begin
			@(negedge CLOCK_IN);
			ar = S_AXI_ARVALID && S_AXI_ARREADY;
			got = S_AXI_RVALID;
			v = S_AXI_RDATA;
			r = S_AXI_RRESP;
			@(posedge CLOCK_IN);
			if (ar) S_AXI_ARVALID <= 1'b0;
		end
		S_AXI_RREADY <= 1'b0;
		if (!got) tmo();
		chk(r, er);
		@(posedge CLOCK_IN);
	endtask

	// Offer one request and check which outcome pulses: 1 delivered, 2 fault, 3 passed on.
	task automatic irq(input logic [31:0] a, input logic [31:0] d, input logic [1:0] ek,
			input logic [15:0] ex);
		int n;
		logic tk;
		logic [1:0] k;
		logic [63:0] ea;
		k = 2'h0;
		ea = base + {44'h0, ex, 4'h0};
		REQ_ADDR_IN <= a;
		REQ_DATA_IN <= d;
		REQ_VALID_IN <= 1'b1;
		for (n = 0; n < 200 && k == 2'h0; n++) begin
			@(negedge CLOCK_IN);
			if (DLV_VALID_OUT) k = 2'h1;
			if (FAULT_VALID_OUT) k = 2'h2;
			if (COMPAT_VALID_OUT) k = 2'h3;
			tk = REQ_VALID_IN && REQ_READY_OUT;
			@(posedge CLOCK_IN);
			if (tk) REQ_VALID_IN <= 1'b0;
		end
		if (k == 2'h0) tmo();
		chk(k, ek);
		if (ek == 2'h1) begin
			chk(DLV_INDEX_OUT, ex);
			chk(DLV_ENTRY_OUT, {~ea, ea});
		end
		if (ek == 2'h2) chk(FAULT_REASON_OUT, ex[7:0]);
	endtask

	// Main sequence: reset, set up the table, then walk the decode and bounds cases.
	initial begin
		RST_IN = 1'b1;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
		S_AXI_WSTRB = 4'hF;
		{REQ_VALID_IN, REQ_ADDR_IN, REQ_DATA_IN, mem_slow, mem_err} = 67'h0;
		{fail_count, checks_done, fetches} = 96'h0;
		base = 64'h0000_0000_0001_0000;
		repeat (8) @(posedge CLOCK_IN);
		RST_IN <= 1'b0;
		@(posedge CLOCK_IN);
		rd(OFS_CTRL, RESP_OKAY, rv);
		chk(rv, 32'h0000_0000);
		rd(OFS_COUNT, RESP_OKAY, rv);
		chk(rv, 32'h0000_0000);
		rd(8'h1C, RESP_SLVERR, rv);
		chk(rv, 32'h0000_0000);
		wr(8'h1C, 32'h0000_0001, RESP_SLVERR);
		wr(OFS_BASE_LO, 32'h0001_0000, RESP_OKAY);
		wr(OFS_BASE_HI, 32'h0000_0000, RESP_OKAY);
		wr(OFS_COUNT, 32'h0000_0100, RESP_OKAY);
		wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		irq(ra(16'h0005, 1'b0, 2'h3), 32'hFFFF_FFFF, 2'h1, 16'h0005);
		irq(ra(16'h0010, 1'b1, 2'h2), 32'h0000_0020, 2'h1, 16'h0030);
		f0 = fetches;
		irq(ra(16'h0030, 1'b0, 2'h1), 32'h0000_0000, 2'h1, 16'h0030);
		chk(fetches, f0);
		mem_slow <= 1'b1;
		wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
		irq(ra(16'h0030, 1'b0, 2'h0), 32'h0000_0000, 2'h1, 16'h0030);
		chk(fetches, f0 + 1);
		mem_slow <= 1'b0;
		irq(ra(16'h0100, 1'b0, 2'h0), 32'h0000_0000, 2'h2, 16'h0021);
		irq(ra(16'h00F0, 1'b1, 2'h0), 32'h0000_000F, 2'h1, 16'h00FF);
		irq(ra(16'h0001, 1'b1, 2'h0), 32'h0001_0000, 2'h2, 16'h0020);
		irq(ra(16'h0001, 1'b0, 2'h0) & 32'hFFFF_FFEF, 32'h0, 2'h3, 16'h0);
		wr(OFS_COUNT, 32'h0001_0001, RESP_OKAY);
		rd(OFS_COUNT, RESP_OKAY, rv);
		chk(rv, 32'h0000_0100);
		rd(OFS_STATUS, RESP_OKAY, rv);
		chk(rv[STS_SZERR_POS], 1'b1);
		wr(OFS_COUNT, 32'h0001_0000, RESP_OKAY);
		irq(ra(16'h8001, 1'b0, 2'h1), 32'h0000_0000, 2'h1, 16'h8001);
		wr(OFS_INV_IDX, 32'h0000_8001, RESP_OKAY);
		f0 = fetches;
		irq(ra(16'h8001, 1'b0, 2'h0), 32'h0000_0000, 2'h1, 16'h8001);
		chk(fetches, f0 + 1);
		irq(ra(16'hFFFF, 1'b1, 2'h0), 32'h0000_0001, 2'h2, 16'h0021);
		mem_err <= 1'b1;
		irq(ra(16'h0002, 1'b0, 2'h0), 32'h0000_0000, 2'h2, 16'h0023);
		mem_err <= 1'b0;
		base = 64'h0001_0000_0001_0000;
		wr(OFS_BASE_HI, 32'h0001_0000, RESP_OKAY);
		irq(ra(16'h0003, 1'b0, 2'h0), 32'h0000_0000, 2'h2, 16'h0021);
		rd(OFS_LAST, RESP_OKAY, rv);
		chk(rv, 32'h0000_0003);
		rd(OFS_STATUS, RESP_OKAY, rv);
		chk(rv, 32'h0000_0321);
		wr(OFS_STATUS, 32'h0000_0300, RESP_OKAY);
		rd(OFS_STATUS, RESP_OKAY, rv);
		chk(rv, 32'h0000_0021);
		test_done();
	end
endmodule // test_remappable_irq_index_decode
`default_nettype wire
